// ---- bench/jpf_framer_assertions.sv ----
// checker on the framer's top ports
// assumes one clock and the synchronous active-high reset
`timescale 1ns/1ns
module jpf_framer_chk (
  input logic clock,
  input logic sys_rst,
  input logic cfg_write,
  input logic [3:0] cfg_group,
  input logic cfg_enable,
  input logic [7:0] source_address_byte,
  input logic frame_valid,
  input logic frame_ready,
  input logic [28:0] frame_id,
  input logic [63:0] frame_data,
  input logic [8:0] group_enabled
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_stall;
    frame_valid && !frame_ready;
  endsequence
  chk_hold_stall: assert property (s_stall |=> frame_valid && $stable(frame_id)
    && $stable(frame_data)) else $error("frame moved while stalled");
  chk_id_zero: assert property (frame_valid |-> frame_id[25:24] == 2'h0)
    else $error("reserved or page bit set");
  chk_fmt_bcast: assert property (frame_valid |-> frame_id[23:20] == 4'hf)
    else $error("format byte below 240");
  chk_src_byte: assert property (frame_valid |-> frame_id[7:0] == source_address_byte)
    else $error("source byte wrong");
  chk_g3_fill: assert property (frame_valid && frame_id[23:8] == 16'hf02a
    |-> frame_data[55:54] == 2'h3) else $error("group 3 fill bits");
  chk_en_write: assert property (cfg_write && cfg_group inside {[1:9]}
    |=> group_enabled[$past(cfg_group) - 4'd1] == $past(cfg_enable)) else $error("enable lost");
  chk_bad_group: assert property (cfg_write && !(cfg_group inside {[1:9]})
    |=> $stable(group_enabled)) else $error("bad group taken");
  chk_rst_state: assert property ($past(sys_rst) |-> group_enabled == 9'h012
    && !frame_valid) else $error("state after reset");
endmodule // jpf_framer_chk
bind jpf_framer jpf_framer_chk i_jpf_framer_chk (.clock(clock), .sys_rst(sys_rst),
  .cfg_write(cfg_write), .cfg_group(cfg_group), .cfg_enable(cfg_enable),
  .source_address_byte(source_address_byte), .frame_valid(frame_valid),
  .frame_ready(frame_ready), .frame_id(frame_id), .frame_data(frame_data),
  .group_enabled(group_enabled));

// ---- bench/jpf_framer_tb.sv ----
// self-checking bench for the framer with a receiving node
// assumes a 4 ns clock; the millisecond is shortened to MS cycles
`timescale 1ns/1ns
module jpf_framer_tb;
  localparam int MS = 20;
  logic clock = 0, sys_rst = 1, cw = 0, ce = 0, stall = 0, slow = 0;
  logic frame_valid, frame_ready, rx_strobe;
  logic [3:0] cg = 0;
  logic [2:0] cp = 0;
  logic [15:0] cc = 16'h0002;
  logic [7:0] cl = 0, sa = 8'h5a;
  logic [63:0] m = 64'hc35a_9617_e2d4_7b08, frame_data;
  logic [28:0] frame_id;
  logic [8:0] group_enabled;
  logic [92:0] rx_frame, last [1:9];
  logic [7:0] lowb [1:9];
  logic [2:0] prio [1:9];
  int cnt [1:9], t_prev [1:9], per [1:9];
  int cyc = 0, failures = 0, n_tests = 0;
  wire [255:0] prop = {~m, m[31:0], m[63:32], ~m[31:0], ~m[63:32], m};
  jpf_framer #(.MS_CYCLES(MS)) i_jpf_framer (.clock(clock), .sys_rst(sys_rst),
    .cfg_write(cw), .cfg_group(cg), .cfg_enable(ce), .cfg_cycle_ms(cc),
    .cfg_priority(cp), .cfg_low_byte(cl), .source_address_byte(sa), .g1_pitch(m[15:0]),
    .g1_roll(m[31:16]), .g1_pitch_rate(m[47:32]), .g1_status(m[55:48]), .g1_latency(m[63:56]),
    .g2_pitch(m[23:0]), .g2_roll(m[47:24]), .g2_status(m[55:48]), .g2_latency(m[63:56]),
    .g3_pitch_rate(m[15:0]), .g3_roll_rate(m[31:16]), .g3_yaw_rate(m[47:32]),
    .g3_status(m[53:48]), .g3_latency(m[63:56]), .g4_lateral(m[15:0]),
    .g4_longitudinal(m[31:16]), .g4_vertical(m[47:32]), .g4_status(m[53:48]),
    .g4_rate_code(m[55:54]), .g5_incl_x(m[15:0]), .g5_incl_y(m[31:16]), .prop_payload(prop),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_id(frame_id),
    .frame_data(frame_data), .group_enabled(group_enabled));
  jpf_node_model i_jpf_node_model (.clock(clock), .stall(stall), .slow(slow),
    .frame_valid(frame_valid), .frame_id(frame_id), .frame_data(frame_data),
    .frame_ready(frame_ready), .rx_strobe(rx_strobe), .rx_frame(rx_frame));
  function automatic logic [15:0] pgn_of(int g);
    case (g)
      1: return 16'hf013;
      2: return 16'hf029;
      3: return 16'hf02a;
      4: return 16'hf02d;
      default: return {8'hff, lowb[g]};
    endcase
  endfunction
  function automatic logic [63:0] data_of(int g);
    case (g)
      1, 2: return m;
      3: return {m[63:56], 2'h3, m[53:0]};
      4: return {8'hff, m[55:0]};
      5: return {32'hffff_ffff, m[31:0]};
      default: return prop[(g - 6) * 64 +: 64];
    endcase
  endfunction
  task automatic chk(string what, logic [92:0] exp, logic [92:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_grp(int g);
    chk("frame", {prio[g], 2'h0, pgn_of(g), sa, data_of(g)}, last[g]);
  endtask
  task automatic cfg(int g, logic en, logic [2:0] pr, logic [7:0] lb, logic [15:0] cy);
    @(posedge clock);
    cw <= 1;
    cg <= 4'(g);
    ce <= en;
    cp <= pr;
    cl <= lb;
    cc <= cy;
    @(posedge clock);
    cw <= 0;
  endtask
  task automatic clear_log;
    for (int g = 1; g <= 9; g++) begin
      last[g] = 0;
      cnt[g] = 0;
    end
  endtask
  task automatic check_all;
    clear_log;
    repeat (300) @(posedge clock);
    for (int g = 1; g <= 9; g++) check_grp(g);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // frames are logged by group number so late ones replace early ones
  always @(posedge clock) begin
    cyc <= cyc + 1;
    for (int g = 1; g <= 9; g++)
      if (rx_strobe && rx_frame[87:72] === pgn_of(g)) begin
        last[g] <= rx_frame;
        cnt[g] <= cnt[g] + 1;
        per[g] <= cyc - t_prev[g];
        t_prev[g] <= cyc;
      end
  end
  initial forever #2 clock = ~clock;
  initial begin
    repeat (8000) @(posedge clock);
    failures++;
    close_out;
  end
  initial begin
    for (int g = 1; g <= 9; g++) begin
      prio[g] = 3'h6;
      lowb[g] = 8'(g - 5);
    end
    repeat (3) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    chk("enables", 9'h012, group_enabled);
    repeat (1000) @(posedge clock);
    chk("period", 10 * MS, per[2]);
    chk("period", 10 * MS, per[5]);
    chk("off", 0, cnt[1] + cnt[3] + cnt[4] + cnt[6] + cnt[7] + cnt[8] + cnt[9]);
    check_grp(2);
    check_grp(5);
    // group 2 wins every tie, so its period stays exact at a new cycle time
    cfg(2, 1, 3'h6, 8'h00, 16'h0003);
    repeat (200) @(posedge clock);
    chk("period", 3 * MS, per[2]);
    cfg(0, 1, 3'h1, 8'h00, 16'h0002);
    cfg(10, 1, 3'h1, 8'h00, 16'h0002);
    @(posedge clock);
    chk("refused", 9'h012, group_enabled);
    for (int g = 1; g <= 9; g++) begin
      prio[g] = 3'(g);
      lowb[g] = 8'(8'h40 + g);
      cfg(g, 1, prio[g], lowb[g], 16'h0002);
    end
    @(posedge clock);
    chk("enables", 9'h1ff, group_enabled);
    check_all;
    // long stall fills the queue; the slow drain then must still give fresh frames
    m <= ~m;
    stall <= 1;
    repeat (1500) @(posedge clock);
    stall <= 0;
    slow <= 1;
    check_all;
    for (int g = 1; g <= 9; g++) cfg(g, 0, prio[g], lowb[g], 16'h0002);
    repeat (100) @(posedge clock);
    clear_log;
    repeat (500) @(posedge clock);
    chk("silent", 0, cnt[1] + cnt[2] + cnt[3] + cnt[4] + cnt[5] + cnt[6] + cnt[7]
      + cnt[8] + cnt[9]);
    chk("enables", 9'h000, group_enabled);
    close_out;
  end
endmodule // jpf_framer_tb

// ---- bench/jpf_node_model.sv ----
// receiving node: takes frames, may stall or accept every other cycle
// assumes the framer's valid/ready handshake on one clock
`timescale 1ns/1ns
module jpf_node_model (
  input logic clock,
  input logic stall,
  input logic slow,
  input logic frame_valid,
  input logic [28:0] frame_id,
  input logic [63:0] frame_data,
  output logic frame_ready,
  output logic rx_strobe,
  output logic [92:0] rx_frame
);
  initial frame_ready = 0;
  initial rx_strobe = 0;
  always @(posedge clock) begin
    rx_strobe <= frame_valid && frame_ready;
    rx_frame <= {frame_id, frame_data};
    frame_ready <= !stall && !(slow && frame_ready);
  end
endmodule // jpf_node_model

// ---- hw/jpf_cycle_timer.v ----
// per-group cycle timer counting millisecond ticks
// assumes tick is a one-cycle enable once per millisecond
`timescale 1ns/1ns
module jpf_cycle_timer #(
  parameter W = 16
) (
  input wire clock,
  input wire sys_rst,
  input wire tick,
  input wire enable,
  input wire [W-1:0] cycle_ms,
  output reg due
);
  reg [W-1:0] elapsed;
  wire [W-1:0] limit;
  // a zero cycle time would fire on every tick, so it acts as one millisecond
  assign limit = (cycle_ms == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : cycle_ms;
  always @(posedge clock) begin
    if (sys_rst) begin
      elapsed <= {W{1'b0}};
      due <= 1'b0;
    end else begin
      due <= 1'b0;
      if (!enable) begin
        elapsed <= {W{1'b0}};
      end else if (tick) begin
        if (elapsed + 1'b1 >= limit) begin
          elapsed <= {W{1'b0}};
          due <= 1'b1;
        end else begin
          elapsed <= elapsed + 1'b1;
        end
      end
    end
  end
endmodule // jpf_cycle_timer

// ---- hw/jpf_fifo.v ----
// flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module jpf_fifo #(
  parameter WIDTH = 93,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // jpf_fifo

// ---- hw/jpf_framer.v ----
// top of the process-data framer: settings, timers, payload packing, frame queue
// assumes measurement inputs arrive already scaled to their wire codes
`timescale 1ns/1ns
`include "jpf_regs.vh"
module jpf_framer #(
  parameter MS_CYCLES = `JPF_MS_NS / `JPF_CLK_PERIOD_NS,
  parameter CYC_W = 16
) (
  input wire clock,
  input wire sys_rst,
  input wire cfg_write,
  input wire [3:0] cfg_group,
  input wire cfg_enable,
  input wire [CYC_W-1:0] cfg_cycle_ms,
  input wire [2:0] cfg_priority,
  input wire [7:0] cfg_low_byte,
  input wire [7:0] source_address_byte,
  input wire [15:0] g1_pitch,
  input wire [15:0] g1_roll,
  input wire [15:0] g1_pitch_rate,
  input wire [7:0] g1_status,
  input wire [7:0] g1_latency,
  input wire [23:0] g2_pitch,
  input wire [23:0] g2_roll,
  input wire [7:0] g2_status,
  input wire [7:0] g2_latency,
  input wire [15:0] g3_pitch_rate,
  input wire [15:0] g3_roll_rate,
  input wire [15:0] g3_yaw_rate,
  input wire [5:0] g3_status,
  input wire [7:0] g3_latency,
  input wire [15:0] g4_lateral,
  input wire [15:0] g4_longitudinal,
  input wire [15:0] g4_vertical,
  input wire [5:0] g4_status,
  input wire [1:0] g4_rate_code,
  input wire [15:0] g5_incl_x,
  input wire [15:0] g5_incl_y,
  input wire [255:0] prop_payload,
  output reg frame_valid,
  input wire frame_ready,
  output reg [28:0] frame_id,
  output reg [63:0] frame_data,
  output reg [8:0] group_enabled
);
  localparam NG = `JPF_NUM_GROUPS;
  localparam S_IDLE = 2'b01;
  localparam S_PUSH = 2'b10;
  localparam [15:0] PGN_PROP = `JPF_PGN_PROP;

  reg [CYC_W-1:0] cycle_ms [0:NG-1];
  reg [2:0] prio_set [0:NG-1];
  reg [7:0] low_byte [0:`JPF_NUM_PROP-1];
  reg [8:0] pending;
  reg [8:0] clear_mask;
  reg [1:0] state;
  reg [28:0] build_id;
  reg [63:0] build_data;
  reg [28:0] next_id;
  reg [63:0] next_data;
  reg [15:0] pgn;
  reg [31:0] ms_count;
  reg ms_tick;
  reg [3:0] sel;
  wire [8:0] due;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`JPF_FRAME_W-1:0] fifo_out_data;
  wire out_load;
  integer i;

  function [3:0] lowest_set;
    input [8:0] v;
    integer k;
    begin
      lowest_set = 4'h0;
      for (k = NG - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          lowest_set = k[3:0];
        end
      end
    end
  endfunction

  // proprietary number: fixed high byte, settable low byte
  function [15:0] prop_pgn;
    input [7:0] low;
    begin
      prop_pgn = {PGN_PROP[15:8], low};
    end
  endfunction

  // millisecond enable pulse
  always @(posedge clock) begin
    if (sys_rst) begin
      ms_count <= 32'h00000000;
      ms_tick <= 1'b0;
    end else if (ms_count == MS_CYCLES - 1) begin
      ms_count <= 32'h00000000;
      ms_tick <= 1'b1;
    end else begin
      ms_count <= ms_count + 32'h00000001;
      ms_tick <= 1'b0;
    end
  end

  // per-group settings, written one group at a time (cfg_group 1..9)
  always @(posedge clock) begin
    if (sys_rst) begin
      group_enabled <= `JPF_DEF_ENABLE;
      for (i = 0; i < NG; i = i + 1) begin
        cycle_ms[i] <= `JPF_DEF_CYCLE_MS;
        prio_set[i] <= `JPF_DEF_PRIO;
      end
      for (i = 0; i < `JPF_NUM_PROP; i = i + 1) begin
        low_byte[i] <= i[7:0];
      end
    end else if (cfg_write && cfg_group != 4'h0 && cfg_group <= NG[3:0]) begin
      group_enabled[cfg_group - 4'h1] <= cfg_enable;
      cycle_ms[cfg_group - 4'h1] <= cfg_cycle_ms;
      prio_set[cfg_group - 4'h1] <= cfg_priority;
      if (cfg_group > `JPF_PROP_FIRST) begin
        low_byte[cfg_group - `JPF_PROP_FIRST - 1] <= cfg_low_byte;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NG; g = g + 1) begin : gen_timer
      jpf_cycle_timer #(
        .W(CYC_W)
      ) u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(ms_tick),
        .enable(group_enabled[g]),
        .cycle_ms(cycle_ms[g]),
        .due(due[g])
      );
    end
  endgenerate

  // group number and payload of the selected group
  always @* begin
    sel = lowest_set(pending);
    pgn = `JPF_PGN_PROP;
    next_data = {8{`JPF_FILL_BYTE}};
    case (sel)
      4'h0: begin
        pgn = `JPF_PGN_G1;
        next_data = {g1_latency, g1_status, g1_pitch_rate, g1_roll, g1_pitch};
      end
      4'h1: begin
        pgn = `JPF_PGN_G2;
        next_data = {g2_latency, g2_status, g2_roll, g2_pitch};
      end
      4'h2: begin
        pgn = `JPF_PGN_G3;
        next_data = {g3_latency, `JPF_FILL_PAIR, g3_status,
                     g3_yaw_rate, g3_roll_rate, g3_pitch_rate};
      end
      4'h3: begin
        pgn = `JPF_PGN_G4;
        next_data = {`JPF_FILL_BYTE, g4_rate_code, g4_status,
                     g4_vertical, g4_longitudinal, g4_lateral};
      end
      4'h4: begin
        pgn = prop_pgn(low_byte[0]);
        next_data = {{4{`JPF_FILL_BYTE}}, g5_incl_y, g5_incl_x};
      end
      4'h5, 4'h6, 4'h7, 4'h8: begin
        // euler, quaternion, acceleration, yaw rate: content comes ready packed
        pgn = prop_pgn(low_byte[sel - `JPF_PROP_FIRST]);
        next_data = prop_payload[(sel - `JPF_PROP_FIRST - 1) * 64 +: 64];
      end
      default: begin
        pgn = `JPF_PGN_PROP;
        next_data = {8{`JPF_FILL_BYTE}};
      end
    endcase
    // every group number here has a format byte of 0xf0 or more, so no destination
    next_id = {prio_set[sel], `JPF_RESERVED_BIT, `JPF_DATA_PAGE,
               pgn, source_address_byte};
  end

  // pick the lowest pending group, then queue its frame
  always @(posedge clock) begin
    if (sys_rst) begin
      state <= S_IDLE;
      build_id <= 29'h00000000;
      build_data <= 64'h0000000000000000;
      clear_mask <= 9'h000;
    end else begin
      clear_mask <= 9'h000;
      case (state)
        S_IDLE: begin
          if (pending != 9'h000) begin
            build_id <= next_id;
            build_data <= next_data;
            clear_mask <= 9'h001 << sel;
            state <= S_PUSH;
          end
        end
        S_PUSH: begin
          if (fifo_in_ready) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // a new due in the clearing cycle keeps the group pending
  always @(posedge clock) begin
    if (sys_rst) begin
      pending <= 9'h000;
    end else begin
      pending <= (pending & ~clear_mask) | (due & group_enabled);
    end
  end

  jpf_fifo #(
    .WIDTH(`JPF_FRAME_W),
    .DEPTH(`JPF_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(state == S_PUSH),
    .in_ready(fifo_in_ready),
    .in_data({build_id, build_data}),
    .out_valid(fifo_out_valid),
    .out_ready(out_load),
    .out_data(fifo_out_data)
  );

  // output stage keeps the frame ports on flip-flops
  assign out_load = !frame_valid || frame_ready;
  always @(posedge clock) begin
    if (sys_rst) begin
      frame_valid <= 1'b0;
      frame_id <= 29'h00000000;
      frame_data <= 64'h0000000000000000;
    end else if (out_load) begin
      frame_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        frame_id <= fifo_out_data[92:64];
        frame_data <= fifo_out_data[63:0];
      end
    end
  end
endmodule // jpf_framer

// ---- hw/jpf_regs.vh ----
// constants of the process-data framer: group numbers, defaults, timing
// assumes the includer works at a 4 ns clock and sees bit n of a payload as data bit n
`ifndef JPF_REGS_VH
`define JPF_REGS_VH
`define JPF_NUM_GROUPS 9
`define JPF_NUM_PROP 5
`define JPF_PROP_FIRST 4
`define JPF_PGN_G1 16'hf013
`define JPF_PGN_G2 16'hf029
`define JPF_PGN_G3 16'hf02a
`define JPF_PGN_G4 16'hf02d
`define JPF_PGN_PROP 16'hff00
`define JPF_DEF_ENABLE 9'h012
`define JPF_DEF_CYCLE_MS 16'h000a
`define JPF_DEF_PRIO 3'h6
`define JPF_RESERVED_BIT 1'b0
`define JPF_DATA_PAGE 1'b0
`define JPF_FILL_BYTE 8'hff
`define JPF_FILL_PAIR 2'h3
`define JPF_CLK_PERIOD_NS 4
`define JPF_MS_NS 1000000
`define JPF_FRAME_W 93
`define JPF_FIFO_DEPTH 8
`endif
